// ==== design/skip_exec.sv ====
// Executor for increment-and-skip and bit-test-skip instructions
`default_nettype none

// Functional notes
// - Memory increment writes back, skips on zero
// - Skipping inserts dummy cycle, three cycles total
// - Accumulator increment leaves memory byte unchanged
// - Accumulator increment skips when result zero
// - Bit test skips when selected bit set
module skip_exec (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    input wire skip_exec_pkg::op_t op,
    input wire logic [skip_exec_pkg::ADDR_W-1:0] addr,
    input wire logic [skip_exec_pkg::BIT_SEL_W-1:0] bit_sel,
    input wire logic [skip_exec_pkg::DATA_W-1:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic skip,
    output logic dummy_cycle,
    output logic mem_we,
    output logic [skip_exec_pkg::ADDR_W-1:0] mem_addr,
    output logic [skip_exec_pkg::DATA_W-1:0] mem_wdata,
    output logic acc_we,
    output logic [skip_exec_pkg::DATA_W-1:0] acc
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // Decode and result
    // ----------------------------------------
    wire logic op_inc_mem = (op == skip_exec_pkg::OP_INC_MEM);
    wire logic op_inc_acc = (op == skip_exec_pkg::OP_INC_ACC);
    wire logic op_bit_test = (op == skip_exec_pkg::OP_BIT_TEST);
    wire logic valid_op = start && (op != skip_exec_pkg::OP_NONE);
    wire logic [skip_exec_pkg::DATA_W-1:0] inc_sum = mem_rdata + skip_exec_pkg::ONE;
    wire logic sum_zero = (inc_sum == skip_exec_pkg::ZERO);
    wire logic bit_set = mem_rdata[bit_sel];
    wire logic skip_cond = op_bit_test ? bit_set : sum_zero;

    // ----------------------------------------
    // Instruction sequencing
    // ----------------------------------------
    skip_exec_pkg::state_t state_q;
    skip_exec_pkg::state_t state_d;
    logic [skip_exec_pkg::ADDR_W-1:0] addr_q;
    logic [skip_exec_pkg::DATA_W-1:0] wdata_q;
    logic mem_we_q;
    logic acc_we_q;
    logic skip_q;
    logic done_q;
    logic [skip_exec_pkg::DATA_W-1:0] acc_q;

    wire logic take = (state_q == skip_exec_pkg::ST_IDLE) && valid_op;

    always_comb begin
        state_d = state_q;
        case (state_q)
            skip_exec_pkg::ST_IDLE: begin
                if (valid_op) begin
                    state_d = skip_cond ? skip_exec_pkg::ST_FETCH : skip_exec_pkg::ST_IDLE;
                end
            end
            skip_exec_pkg::ST_FETCH: state_d = skip_exec_pkg::ST_DUMMY;
            skip_exec_pkg::ST_DUMMY: state_d = skip_exec_pkg::ST_IDLE;
            default: state_d = skip_exec_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= skip_exec_pkg::ST_IDLE;
            addr_q <= '0;
            wdata_q <= skip_exec_pkg::ZERO;
            mem_we_q <= 1'b0;
            acc_we_q <= 1'b0;
            skip_q <= 1'b0;
            done_q <= 1'b0;
            acc_q <= skip_exec_pkg::ACC_RESET;
        end else begin
            state_q <= state_d;
            mem_we_q <= take && op_inc_mem;
            acc_we_q <= take && op_inc_acc;
            done_q <= (take && !skip_cond) || (state_q == skip_exec_pkg::ST_DUMMY);
            if (take) begin
                addr_q <= addr;
                wdata_q <= inc_sum;
                skip_q <= skip_cond;
            end
            if (take && op_inc_acc) begin
                acc_q <= inc_sum;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign busy = (state_q != skip_exec_pkg::ST_IDLE);
    assign done = done_q;
    assign skip = skip_q;
    assign dummy_cycle = (state_q == skip_exec_pkg::ST_DUMMY);
    assign mem_we = mem_we_q;
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;
    assign acc_we = acc_we_q;
    assign acc = acc_q;

    // ----------------------------------------
    // Instruction cycle count for the checks
    // ----------------------------------------
    localparam logic [1:0] CYC_PLAIN = 2'(skip_exec_pkg::PLAIN_CYCLES);
    localparam logic [1:0] CYC_SKIP = 2'(skip_exec_pkg::SKIP_CYCLES);
    logic [1:0] instr_cyc_q;
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            instr_cyc_q <= '0;
        end else if (take) begin
            instr_cyc_q <= CYC_PLAIN;
        end else if (busy) begin
            instr_cyc_q <= instr_cyc_q + 2'h1;
        end
    end

    // ----------------------------------------
    // Checks: data path
    // ----------------------------------------
    a_mem_write_sum: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && op_inc_mem
        |=> mem_we && mem_wdata == $past(mem_rdata) + skip_exec_pkg::ONE)
        else $error("memory increment not written back");

    a_addr_captured: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take
        |=> mem_addr == $past(addr))
        else $error("operand address not captured");

    a_mem_skip_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && op_inc_mem
        |=> skip == (mem_wdata == skip_exec_pkg::ZERO))
        else $error("memory increment skip mismatch");

    a_acc_no_mem: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && op_inc_acc
        |=> !mem_we && acc_we && acc == $past(mem_rdata) + skip_exec_pkg::ONE)
        else $error("accumulator increment wrong");

    a_acc_kept: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        !(take && op_inc_acc)
        |=> $stable(acc))
        else $error("accumulator changed without increment");

    a_we_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        1'b1
        |-> !(mem_we && acc_we))
        else $error("memory and accumulator written together");

    a_acc_skip_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && op_inc_acc
        |=> skip == (acc == skip_exec_pkg::ZERO))
        else $error("accumulator skip mismatch");

    a_bit_skip: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && op_bit_test
        |=> skip == $past(mem_rdata[bit_sel]) && !mem_we)
        else $error("bit test skip mismatch");

    a_bit_no_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && op_bit_test
        |=> !acc_we && $stable(acc))
        else $error("bit test touched the accumulator");

    // ----------------------------------------
    // Checks: instruction timing
    // ----------------------------------------
    a_skip_three_cycles: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && skip_cond
        |=> busy ##1 dummy_cycle ##1 !busy && done)
        else $error("skip did not take three cycles");

    a_dummy_single: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        dummy_cycle
        |=> !dummy_cycle)
        else $error("dummy cycle longer than one cycle");

    a_dummy_after_fetch: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        dummy_cycle
        |-> $past(busy) && !$past(dummy_cycle))
        else $error("dummy cycle without fetch cycle");

    a_busy_refused: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        busy
        |=> !mem_we && !acc_we)
        else $error("start accepted while busy");

    a_skip_cycle_count: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        done && skip
        |-> instr_cyc_q == CYC_SKIP)
        else $error("skipping instruction cycle count wrong");

    a_no_skip_single: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        take && !skip_cond
        |=> done && !busy && !dummy_cycle)
        else $error("non-skip not single cycle");

    a_plain_cycle_count: assert property (@(posedge ref_clk) disable iff (!rst_sync_q)
        done && !skip
        |-> instr_cyc_q == CYC_PLAIN)
        else $error("non-skip instruction cycle count wrong");
endmodule // skip_exec
`default_nettype wire

// ==== common/skip_exec_pkg.sv ====
// Package of constants for the increment-skip and bit-test-skip executor
`default_nettype none
package skip_exec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam logic [DATA_W-1:0] ONE = 8'h01;
    localparam logic [DATA_W-1:0] ZERO = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    // Cycles taken by an instruction that skips
    localparam int SKIP_CYCLES = 3;
    // Cycles taken by an instruction that does not skip
    localparam int PLAIN_CYCLES = 1;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_INC_MEM = 2'h1,
        OP_INC_ACC = 2'h2,
        OP_BIT_TEST = 2'h3
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_FETCH = 2'h2,
        ST_DUMMY = 2'h3
    } state_t;
endpackage
`default_nettype wire

// ==== verif/test_skip_exec.sv ====
// Testbench for the increment-skip and bit-test-skip executor
`default_nettype none
module test_skip_exec;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] d;
        logic [2:0] b;
        logic s;
        logic mw;
        logic aw;
    } row_t;
    // ----------------------------------------
    // Rows: op, operand, bit, skip, mem write, acc write
    // ----------------------------------------
    row_t rows [7] = '{'{2'h1, 8'hff, 3'h0, 1'b1, 1'b1, 1'b0}, '{2'h1, 8'h7f, 3'h0, 1'b0, 1'b1, 1'b0},
        '{2'h2, 8'hff, 3'h0, 1'b1, 1'b0, 1'b1}, '{2'h2, 8'h00, 3'h0, 1'b0, 1'b0, 1'b1},
        '{2'h3, 8'h80, 3'h7, 1'b1, 1'b0, 1'b0}, '{2'h3, 8'h7f, 3'h7, 1'b0, 1'b0, 1'b0},
        '{2'h3, 8'h01, 3'h0, 1'b1, 1'b0, 1'b0}};
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    skip_exec_pkg::op_t op = skip_exec_pkg::OP_NONE;
    logic [7:0] addr = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] mem_rdata = 8'h00;
    logic busy, done, skip, dummy_cycle, mem_we, acc_we;
    logic [7:0] mem_addr, mem_wdata, acc;
    int fail_count = 0;
    int n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    skip_exec uut (.ref_clk(ref_clk), .rstn(rstn), .start(start), .op(op), .addr(addr),
        .bit_sel(bit_sel), .mem_rdata(mem_rdata), .busy(busy), .done(done), .skip(skip),
        .dummy_cycle(dummy_cycle), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .acc_we(acc_we), .acc(acc));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic run(input row_t r);
        logic [7:0] sum;
        sum = r.d + 8'h01;
        start <= 1'b1;
        op <= skip_exec_pkg::op_t'(r.op);
        addr <= ~r.d;
        bit_sel <= r.b;
        mem_rdata <= r.d;
        @(posedge ref_clk);
        start <= 1'b0;
        @(negedge ref_clk);
        chk("skip", {7'h00, r.s}, {7'h00, skip});
        chk("mem_we", {7'h00, r.mw}, {7'h00, mem_we});
        chk("acc_we", {7'h00, r.aw}, {7'h00, acc_we});
        chk("done", {7'h00, ~r.s}, {7'h00, done});
        chk("busy", {7'h00, r.s}, {7'h00, busy});
        if (r.mw) chk("mem_wdata", sum, mem_wdata);
        if (r.mw) chk("mem_addr", ~r.d, mem_addr);
        if (r.aw) chk("acc", sum, acc);
        if (r.s) begin
            @(negedge ref_clk);
            chk("dummy_cycle", 8'h01, {7'h00, dummy_cycle});
            @(negedge ref_clk);
            chk("done_busy", 8'h02, {6'h00, done, busy});
        end else begin
            @(negedge ref_clk);
            chk("no_dummy", 8'h00, {6'h00, dummy_cycle, busy});
        end
        @(posedge ref_clk);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        chk("reset_acc", 8'h00, acc);
        chk("reset_flags", 8'h00, {2'h0, busy, done, skip, dummy_cycle, mem_we, acc_we});
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (rows[i]) run(rows[i]);
        // Start held into the busy window is ignored
        start <= 1'b1;
        op <= skip_exec_pkg::OP_INC_MEM;
        mem_rdata <= 8'hff;
        @(posedge ref_clk);
        op <= skip_exec_pkg::OP_INC_ACC;
        mem_rdata <= 8'h10;
        @(posedge ref_clk);
        start <= 1'b0;
        @(negedge ref_clk);
        chk("acc_we_busy", 8'h00, {7'h00, acc_we});
        chk("acc_busy", 8'h01, acc);
        repeat (3) @(posedge ref_clk);
        // Reset in the middle of a skipping instruction
        start <= 1'b1;
        op <= skip_exec_pkg::OP_INC_MEM;
        mem_rdata <= 8'hff;
        @(posedge ref_clk);
        start <= 1'b0;
        rstn <= 1'b0;
        @(negedge ref_clk);
        chk("mid_reset_acc", 8'h00, acc);
        chk("mid_reset_flags", 8'h00, {2'h0, busy, done, skip, dummy_cycle, mem_we, acc_we});
        @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        run(rows[0]);
        report_and_stop();
    end
endmodule // test_skip_exec
`default_nettype wire
